// ---- design/sso_map.svh ----
// Purpose: constants of the serial sound output block
// Assumes: 32-bit APB data, one register per aligned word
// Notes: definitions only
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH
`define SSO_WIN_LO 32'h0340_0000
`define SSO_WIN_HI 32'h034F_FFFF
`define SSO_VIDEO_MUX_CONFIG_REG_ADDR 32'h0350_0000
`define SSO_STATUS_ADDR 32'h0350_0004
`define SSO_SEL_FREQ 8'hB0
`define SSO_SEL_CTL 8'hB1
`define SSO_FIFO_LAST 3'h3
`define SSO_FIFO_FULL 3'h4
`define SSO_DIV_EXTRA 9'h002
`define SSO_LAST_BIT 5'h1F
`define SSO_WS_NORM_FIRST 5'h0F
`define SSO_WS_NORM_LAST 5'h1E
`define SSO_WS_JP_LAST 5'h0F
`define SSO_BYTE_LAST 3'h7
`define SSO_CTL_CLKSEL 0
`define SSO_CTL_EN_LO 1
`define SSO_CTL_EN_HI 2
`define SSO_VIDEO_MUX_CONFIG_REG_FMT 0
`define SSO_CTL_RESET 3'h0
`define SSO_FREQ_RESET 8'h00
`define SSO_VIDEO_MUX_CONFIG_REG_RESET 2'h0
`endif

// ---- design/sso_pkg.sv ----
// Purpose: shared types of the serial sound output block
// Assumes: constants live in sso_map.svh
// Notes: refill sequencing states
`default_nettype none
package sso_pkg;
   typedef enum logic {
      fill_wait,
      fill_busy
   } sso_fill_type;
endpackage : sso_pkg
`default_nettype wire

// ---- design/sso_top.sv ----
// Purpose: stereo serial sound output with qword refill fifo and byte latch
// Assumes: apb master on pclk; dma words arrive on pclk; ref clock is asynchronous
// Notes: half bit period is (frequency value + 2) ticks of the selected source
`include "sso_map.svh"
`default_nettype none

// Operation
// [RQ1] four word fifo then one byte latch
// [RQ2] refill fully by dma once fifo empty
// [RQ3] bytes move through latch one at a time
// [RQ4] three outputs: bit clock, data, word select
// [RQ5] disabled: clock low, data low, select high
// [RQ6] each byte sent msb first
// [RQ7] parallel load, shifted by bit clock
// [RQ8] mux config bit 0 picks select format
// [RQ9] sample is sixteen left, sixteen right bits
// [RQ10] normal: select toggles on previous lsb
// [RQ11] normal: select high means right channel
// [RQ12] alternate: select toggles on new msb
// [RQ13] alternate: select polarity inverted
// [RQ14] software sets ref clock and divider two
// [RQ15] software sets divider for other rates
// [RQ16] register chosen by upper write data bits
// [RQ17] window write makes active low strobe
// [RQ18] active low dma request to arbiter
// [RQ19] each refill is a four word burst
// [RQ20] software keeps dma pointers qword aligned
// [RQ21] macrocell registers read back as zero
// [RQ22] request drops on fourth burst word
module sso_top (
   input wire logic pclk, // system clock
   input wire logic presetn, // asynchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic dma_word_valid, // one burst word this cycle
   input wire logic [31:0] dma_word, // burst word
   output logic dma_request_n, // refill request, active low
   output logic reg_write_strobe_n, // register write strobe, active low
   input wire logic sound_ref_clk, // external sound reference clock
   output logic serial_bit_clock_out, // serial bit clock
   output logic serial_data_out, // serial data
   output logic channel_select_out // channel word select
);

   logic [2:0] sound_control_reg;
   logic [7:0] sound_freq_reg;
   logic [1:0] video_mux_config_reg;
   logic [31:0] wdata_q;
   logic in_window;
   logic addr_video_mux_config_reg;
   logic addr_status;
   logic apb_done;
   logic snd_en;
   logic fmt_alt;
   sso_pkg::sso_fill_type fill_state;
   logic [31:0] fifo_mem [0:3];
   logic [1:0] wr_ptr;
   logic [1:0] rd_ptr;
   logic [2:0] fifo_count;
   logic [1:0] byte_sel;
   logic [7:0] byte_latch;
   logic latch_full;
   logic fifo_rd;
   logic fifo_push;
   logic ref_meta;
   logic ref_sync;
   logic ref_prev;
   logic div_tick;
   logic [8:0] div_cnt;
   logic [8:0] half_period;
   logic half_event;
   logic fall_event;
   logic shift_load;
   logic [7:0] shift_reg;
   logic [4:0] bit_idx;
   logic [4:0] next_bit_idx;
   logic next_ws;

   assign in_window = (paddr >= `SSO_WIN_LO) && (paddr <= `SSO_WIN_HI);
   assign addr_video_mux_config_reg = (paddr == `SSO_VIDEO_MUX_CONFIG_REG_ADDR);
   assign addr_status = (paddr == `SSO_STATUS_ADDR);
   assign apb_done = psel && penable && pready;
   assign snd_en = (sound_control_reg[`SSO_CTL_EN_HI:`SSO_CTL_EN_LO] != 2'h0);
   assign fmt_alt = video_mux_config_reg[`SSO_VIDEO_MUX_CONFIG_REG_FMT];

   // apb slave: ready in the first access cycle, so no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !in_window && !addr_video_mux_config_reg && !addr_status;
         if (psel && !penable && !pwrite && addr_status) begin
            prdata <= {24'h00_0000, (fill_state == sso_pkg::fill_busy), fifo_count,
                       byte_sel, latch_full, snd_en};
         end else if (psel && !penable && !pwrite && addr_video_mux_config_reg) begin
            prdata <= {30'h0000_0000, video_mux_config_reg};
         end else begin
            prdata <= 32'h0000_0000; // RQ21
         end
      end
   end

   // window writes become a one cycle strobe carrying the data word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_write_strobe_n <= 1'b1;
         wdata_q <= 32'h0000_0000;
      end else begin
         reg_write_strobe_n <= !(apb_done && pwrite && in_window); // RQ17
         if (apb_done && pwrite && in_window) begin
            wdata_q <= pwdata;
         end
      end
   end

   // the strobe carries no address; the top data byte names the target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sound_control_reg <= `SSO_CTL_RESET;
         sound_freq_reg <= `SSO_FREQ_RESET;
      end else if (!reg_write_strobe_n) begin
         if (wdata_q[31:24] == `SSO_SEL_CTL) begin
            sound_control_reg <= wdata_q[2:0]; // RQ16
         end
         if (wdata_q[31:24] == `SSO_SEL_FREQ) begin
            sound_freq_reg <= wdata_q[7:0]; // RQ16
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         video_mux_config_reg <= `SSO_VIDEO_MUX_CONFIG_REG_RESET;
      end else if (apb_done && pwrite && addr_video_mux_config_reg) begin
         video_mux_config_reg <= pwdata[1:0]; // RQ8
      end
   end

   // refill sequencing: request only once empty, drop on the fourth word
   assign fifo_push = dma_word_valid && (fill_state == sso_pkg::fill_busy);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_state <= sso_pkg::fill_wait;
         dma_request_n <= 1'b1;
      end else begin
         unique case (fill_state)
            sso_pkg::fill_wait: begin
               if (snd_en && (fifo_count == 3'h0)) begin
                  fill_state <= sso_pkg::fill_busy; // RQ2
                  dma_request_n <= 1'b0; // RQ18
               end
            end
            sso_pkg::fill_busy: begin
               if (fifo_push && (fifo_count == `SSO_FIFO_LAST)) begin
                  fill_state <= sso_pkg::fill_wait;
                  dma_request_n <= 1'b1; // RQ22
               end
            end
         endcase
      end
   end

   // fifo words: written only while refilling, read only while not;
   // push and pop never share a cycle because push needs fill_busy and pop needs fill_wait
   assign fifo_rd = (fill_state == sso_pkg::fill_wait) && (fifo_count != 3'h0) &&
                    !latch_full && (byte_sel == 2'h3);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= 2'h0;
         rd_ptr <= 2'h0;
         fifo_count <= 3'h0;
      end else begin
         if (fifo_push) begin
            wr_ptr <= wr_ptr + 2'h1;
            fifo_count <= fifo_count + 3'h1; // RQ19
         end else if (fifo_rd) begin
            rd_ptr <= rd_ptr + 2'h1;
            fifo_count <= fifo_count - 3'h1; // RQ1
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (fifo_push) begin
         fifo_mem[wr_ptr] <= dma_word;
      end
   end

   // byte latch: upper byte first, so the left half leaves first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_latch <= 8'h00;
         latch_full <= 1'b0;
         byte_sel <= 2'h0;
      end else begin
         if ((fill_state == sso_pkg::fill_wait) && (fifo_count != 3'h0) && !latch_full) begin
            byte_latch <= fifo_mem[rd_ptr][{~byte_sel, 3'b000} +: 8]; // RQ3
            byte_sel <= byte_sel + 2'h1;
            latch_full <= 1'b1;
         end else if (shift_load) begin
            latch_full <= 1'b0;
         end
      end
   end

   // reference clock crosses by two flops before its edge is looked for
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_prev <= 1'b0;
      end else begin
         ref_meta <= sound_ref_clk;
         ref_sync <= ref_meta;
         ref_prev <= ref_sync;
      end
   end

   assign div_tick = sound_control_reg[`SSO_CTL_CLKSEL] ? (ref_sync && !ref_prev) : 1'b1;
   assign half_period = {1'b0, sound_freq_reg} + `SSO_DIV_EXTRA;
   // >= rather than == so a divider lowered mid-count cannot stall the clock
   assign half_event = snd_en && div_tick && (div_cnt >= half_period - 9'h001);
   assign fall_event = half_event && serial_bit_clock_out;
   assign shift_load = fall_event && (bit_idx[2:0] == `SSO_BYTE_LAST);
   assign next_bit_idx = bit_idx + 5'h01;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 9'h000;
      end else if (!snd_en || half_event) begin
         div_cnt <= 9'h000;
      end else if (div_tick) begin
         div_cnt <= div_cnt + 9'h001;
      end
   end

   // word select as a function of the bit about to be sent
   always_comb begin
      if (fmt_alt) begin
         next_ws = (next_bit_idx <= `SSO_WS_JP_LAST); // RQ12 RQ13
      end else begin
         next_ws = (next_bit_idx >= `SSO_WS_NORM_FIRST) &&
                   (next_bit_idx <= `SSO_WS_NORM_LAST); // RQ10 RQ11
      end
   end

   // data changes on the falling bit clock so the dac samples on the rise;
   // an empty latch at a byte boundary sends silence rather than stale data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_bit_clock_out <= 1'b0;
         serial_data_out <= 1'b0;
         channel_select_out <= 1'b1;
         shift_reg <= 8'h00;
         bit_idx <= `SSO_LAST_BIT;
      end else if (!snd_en) begin
         serial_bit_clock_out <= 1'b0; // RQ5
         serial_data_out <= 1'b0; // RQ5
         channel_select_out <= 1'b1; // RQ5
         shift_reg <= 8'h00;
         bit_idx <= `SSO_LAST_BIT;
      end else if (half_event) begin
         serial_bit_clock_out <= !serial_bit_clock_out; // RQ4
         if (fall_event) begin
            bit_idx <= next_bit_idx; // RQ9
            channel_select_out <= next_ws;
            if (shift_load) begin
               shift_reg <= latch_full ? {byte_latch[6:0], 1'b0} : 8'h00; // RQ7
               serial_data_out <= latch_full && byte_latch[7]; // RQ6
            end else begin
               shift_reg <= {shift_reg[6:0], 1'b0}; // RQ7
               serial_data_out <= shift_reg[7]; // RQ6
            end
         end
      end
   end

   a_idle_levels: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      (!snd_en && $past(!snd_en)) |->
      (!serial_bit_clock_out && !serial_data_out && channel_select_out))
      else $error("outputs not idle while sound disabled");

   a_refill_request: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      (snd_en && fifo_count == 3'h0 && fill_state == sso_pkg::fill_wait) |=>
      (!dma_request_n && fill_state == sso_pkg::fill_busy))
      else $error("empty fifo did not raise refill request");

   a_request_drop: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
      (fifo_push && fifo_count == `SSO_FIFO_LAST) |=>
      (dma_request_n && fifo_count == `SSO_FIFO_FULL))
      else $error("request not dropped on fourth word");

   a_no_drain_fill: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      (fill_state == sso_pkg::fill_busy) |=> $stable(rd_ptr))
      else $error("fifo drained during refill");

   a_fifo_depth: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      fifo_count <= `SSO_FIFO_FULL)
      else $error("fifo count beyond four words");

   a_msb_first: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      (shift_load && latch_full && snd_en) |=> (serial_data_out == $past(byte_latch[7])))
      else $error("byte not started with its msb");

   a_ws_normal: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      (!fmt_alt && snd_en && $past(snd_en) && $rose(channel_select_out)) |->
      (bit_idx == `SSO_WS_NORM_FIRST))
      else $error("normal select rose away from the left lsb");

   a_ws_alt: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      (fmt_alt && snd_en && $past(snd_en) && $fell(channel_select_out)) |->
      (bit_idx == `SSO_WS_JP_LAST + 5'h01))
      else $error("alternate select fell away from the right msb");

   a_bit_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
      (fall_event && bit_idx == `SSO_LAST_BIT) |=> (bit_idx == 5'h00))
      else $error("sample not 32 bits long");

   a_strobe_window: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
      (apb_done && pwrite && in_window) |=> (!reg_write_strobe_n ##1 reg_write_strobe_n))
      else $error("window write made no strobe");

   a_ctl_update: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
      (!reg_write_strobe_n && wdata_q[31:24] == `SSO_SEL_CTL) |=>
      (sound_control_reg == $past(wdata_q[2:0])))
      else $error("sound control not taken from strobe data");

   a_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
      (psel && !penable && !pwrite && in_window) |=> (prdata == 32'h0000_0000))
      else $error("macrocell register read returned data");

   a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (fill_state == sso_pkg::fill_busy) |=> $stable(byte_sel))
      else $error("latch fed during refill");

   a_data_on_fall: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      (snd_en && $past(snd_en) && $changed(serial_data_out)) |->
      $fell(serial_bit_clock_out))
      else $error("data moved away from a falling bit clock");

   a_select_on_fall: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      (snd_en && $past(snd_en) && $changed(channel_select_out)) |->
      $fell(serial_bit_clock_out))
      else $error("select moved away from a falling bit clock");

   a_request_empty: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
      $fell(dma_request_n) |-> (fifo_count == 3'h0 && $past(snd_en)))
      else $error("refill requested with words still in the fifo");

   a_push_in_burst: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
      fifo_push |-> (!dma_request_n && fifo_count < `SSO_FIFO_FULL))
      else $error("burst word taken outside a four word burst");

   a_clock_divider: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      $changed(serial_bit_clock_out) |-> (div_cnt == 9'h000))
      else $error("bit clock moved off a divider boundary");

   a_video_mux_config_reg_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      (apb_done && pwrite && addr_video_mux_config_reg) |=> (video_mux_config_reg == $past(pwdata[1:0])))
      else $error("format select not taken from the bus");

endmodule : sso_top
`default_nettype wire

// ---- tb/sso_dac_model.sv ----
// Purpose: behavioural serial audio dac at the far side of the sound link
// Assumes: data and select are stable at each rising edge of the bit clock
// Notes: records every sampled bit; the first sample after enable carries no data
`default_nettype none
module sso_dac_model (
   input wire logic bit_clk, // serial bit clock from the block
   input wire logic data_in, // serial data from the block
   input wire logic select_in // channel word select from the block
);
   timeunit 1ns;
   timeprecision 100ps;
   logic data_q[$];
   logic sel_q[$];
   realtime last_rise = 0.0;
   int period_ns = 0;

   // a real dac latches on the rising edge only
   always @(posedge bit_clk) begin
      data_q.push_back(data_in);
      sel_q.push_back(select_in);
      period_ns = int'($realtime - last_rise);
      last_rise = $realtime;
   end

   task automatic clear();
      data_q.delete();
      sel_q.delete();
   endtask : clear
endmodule : sso_dac_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of the serial sound output block
// Assumes: dma words are served at once on request, four per burst
// Notes: stream checks compare the dac capture with the words handed to the fifo
`include "sso_map.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, dma_word = 32'h0000_0000;
   logic dma_word_valid = 1'b0, sound_ref_clk = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, dma_request_n, reg_write_strobe_n;
   logic serial_bit_clock_out, serial_data_out, channel_select_out;
   int n_fail = 0, checks = 0, word_n = 0, cycles = 0;

   always #2 pclk = ~pclk;
   always #62.5 sound_ref_clk = ~sound_ref_clk;

   sso_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dma_word_valid(dma_word_valid), .dma_word(dma_word),
      .dma_request_n(dma_request_n), .reg_write_strobe_n(reg_write_strobe_n),
      .sound_ref_clk(sound_ref_clk), .serial_bit_clock_out(serial_bit_clock_out),
      .serial_data_out(serial_data_out), .channel_select_out(channel_select_out));
   sso_dac_model dac (.bit_clk(serial_bit_clock_out), .data_in(serial_data_out),
      .select_in(channel_select_out));

   function automatic logic [31:0] word_of(input int n);
      return 32'h81C3_A55A ^ {4{8'(n)}};
   endfunction : word_of

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   initial forever begin
      @(posedge pclk);
      cycles++;
      if (cycles > 60000) begin
         n_fail++;
         report_and_stop();
      end
   end

   // arbiter and memory: one aligned qword burst per request, then a stray word
   initial forever begin
      @(posedge pclk);
      if (dma_request_n === 1'b0) begin
         for (int k = 0; k < 4; k++) begin
            dma_word_valid <= 1'b1;
            dma_word <= word_of(word_n);
            word_n++;
            @(posedge pclk);
         end
         dma_word <= 32'h5A5A_F00F; // must be ignored, request is high
         @(posedge pclk);
         `CHK("request after burst", 1'b1, dma_request_n)
         dma_word_valid <= 1'b0;
      end
   end

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr_strobes(input logic [31:0] a, input logic [31:0] wd, output int k);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, wd, rd, err);
      k = 0;
      repeat (3) begin
         @(posedge pclk);
         if (reg_write_strobe_n === 1'b0) k++;
      end
   endtask : wr_strobes

   task automatic do_reset();
      presetn <= 1'b0;
      dac.clear();
      word_n = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   task automatic check_idle();
      repeat (20) begin
         @(posedge pclk);
         `CHK("idle bit clock", 1'b0, serial_bit_clock_out)
         `CHK("idle data", 1'b0, serial_data_out)
         `CHK("idle select", 1'b1, channel_select_out)
      end
   endtask : check_idle

   task automatic test_regs();
      logic [31:0] rd;
      logic err;
      int k;
      do_reset();
      check_idle();
      apb(1'b0, `SSO_VIDEO_MUX_CONFIG_REG_ADDR, 32'h0000_0000, rd, err);
      `CHK("mux reset", 32'h0000_0000, rd)
      wr_strobes(`SSO_VIDEO_MUX_CONFIG_REG_ADDR, 32'h0000_0003, k);
      `CHK("strobe outside window", 0, k)
      apb(1'b0, `SSO_VIDEO_MUX_CONFIG_REG_ADDR, 32'h0000_0000, rd, err);
      `CHK("mux readback", 32'h0000_0003, rd)
      apb(1'b0, `SSO_WIN_HI, 32'h0000_0000, rd, err);
      `CHK("window read", 32'h0000_0000, rd)
      `CHK("window read err", 1'b0, err)
      apb(1'b0, 32'h0360_0000, 32'h0000_0000, rd, err);
      `CHK("unmapped err", 1'b1, err)
      wr_strobes(`SSO_WIN_HI, 32'h8000_0006, k);
      `CHK("strobe in window", 1, k)
      `CHK("other selector no request", 1'b1, dma_request_n)
      wr_strobes(`SSO_WIN_LO, {`SSO_SEL_CTL, 24'h00_0002}, k);
      k = 0;
      while (dma_request_n !== 1'b0 && k < 10) begin
         @(posedge pclk);
         k++;
      end
      `CHK("request on empty fifo", 1'b0, dma_request_n)
      wr_strobes(`SSO_WIN_LO, {`SSO_SEL_CTL, 24'h00_0000}, k);
      repeat (10) @(posedge pclk);
      apb(1'b0, `SSO_STATUS_ADDR, 32'h0000_0000, rd, err);
      `CHK("status after burst", 32'h0000_0046, rd)
      $display("test registers done");
   endtask : test_regs

   task automatic run_stream(input logic fmt, input logic clksel, input logic [7:0] div,
                             input int nwords);
      logic [31:0] rd;
      logic err;
      int k, b, half;
      logic [31:0] w;
      logic sel_exp, period_ok;
      do_reset();
      apb(1'b1, `SSO_VIDEO_MUX_CONFIG_REG_ADDR, {31'h0000_0000, fmt}, rd, err);
      wr_strobes(`SSO_WIN_LO, {`SSO_SEL_FREQ, 16'h0000, div}, k);
      wr_strobes(`SSO_WIN_HI, {`SSO_SEL_CTL, 21'h00_0000, 2'b01, clksel}, k);
      while (dac.data_q.size() < 1 + 32 * nwords) begin
         @(posedge pclk);
      end
      for (int i = 0; i < 32 * nwords; i++) begin
         b = i % 32;
         w = word_of(i / 32);
         sel_exp = fmt ? (b <= 15) : (b >= 15 && b <= 30);
         `CHK("serial bit", w[31 - b], dac.data_q[i + 1])
         `CHK("select", sel_exp, dac.sel_q[i + 1])
      end
      half = (int'(div) + 2) * (clksel ? 125 : 4);
      period_ok = (dac.period_ns >= 2 * half - 8) && (dac.period_ns <= 2 * half + 8);
      `CHK("bit period", 1'b1, period_ok)
      wr_strobes(`SSO_WIN_LO, {`SSO_SEL_CTL, 24'h00_0000}, k);
      repeat (3) @(posedge pclk);
      check_idle();
      $display("test stream fmt %0d src %0d done", fmt, clksel);
   endtask : run_stream

   initial begin
      test_regs();
      run_stream(1'b0, 1'b0, 8'h06, 6);
      run_stream(1'b1, 1'b0, 8'h06, 5);
      run_stream(1'b0, 1'b1, 8'h02, 2);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
